// ### rtl/ttc_top.sv
/*
 * Triple timer/counter unit: timers 0 and 1 with four modes each, and
 * timer 2 with capture, auto-reload, up/down and baud modes, reached
 * through a simple special function register port.
 * Assumes pins arrive asynchronously, and that the register port,
 * vector acknowledges and the 6-clock strap are on sys_clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ttc_defs.svh"

module ttc_top
    import ttc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic six_clk_mode_i,
    input wire ttc_pins_s pins_i,
    input wire logic tmr0_vector_ack_i,
    input wire logic tmr1_vector_ack_i,
    input wire logic [3:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    output logic timer0_overflow_flag_o,
    output logic timer1_overflow_flag_o,
    output logic timer2_irq_o,
    output logic timer1_overflow_pulse_o,
    output logic timer2_reload_pulse_o
);

    ttc_state_s s;
    ttc_state_s n;
    logic [3:0] last;
    logic upd;
    logic smp;
    ttc_tmode_s m0;
    ttc_tmode_s m1;
    logic [1:0] md0;
    logic [1:0] md1;
    logic t0m3;
    logic en0;
    logic en1;
    logic inc0;
    logic inc1;
    logic set0;
    logic set1;
    ttc_step_s r0;
    ttc_step_s r1;
    ttc_t2c_s c2;
    logic baud;
    logic updown;
    logic inc2;
    logic ex2;
    logic [15:0] cnt2;
    logic [15:0] cap2;
    logic [15:0] nt2;
    logic [15:0] ncap;
    logic set_tf2;
    logic set_external_trigger_flag;
    logic tog_external_trigger_flag;
    ttc_ctl_s ctl_w;
    ttc_t2c_s t2c_w;

    // One count step of timer 0 or 1 in modes 0, 1 and 2
    function automatic ttc_step_s tstep(input logic [1:0] m,
                                        input logic [7:0] h,
                                        input logic [7:0] l);
        ttc_step_s r;
        r.ovf = 1'b0;
        r.hi = h;
        r.lo = l;
        case (m)
            2'd0: begin
                {r.ovf, r.hi, r.lo[4:0]} = {1'b0, h, l[4:0]} + 14'h0001;
            end
            2'd1: begin
                {r.ovf, r.hi, r.lo} = {1'b0, h, l} + 17'h0_0001;
            end
            2'd2: begin
                r.ovf = &l;
                r.lo = r.ovf ? h : l + 8'h01;
            end
            default: begin
                r.ovf = 1'b0;
            end
        endcase
        return r;
    endfunction

    // Write strobe for one register index
    function automatic logic wsel(input logic [3:0] a);
        return sfr_wr_i && (sfr_addr_i == a);
    endfunction

    // Next-state logic of the whole unit
    always_comb begin
        n = s;
        // Machine cycle of 12 or 6 clocks
        last = six_clk_mode_i ? `TTC_MC6_LAST : `TTC_MC12_LAST;
        upd = (s.phase == `TTC_UPD_PH);
        smp = (s.phase == `TTC_SMP_PH);
        n.phase = (s.phase == last) ? 4'h0 : s.phase + 4'h1;
        // Pin synchronisers, sampling and falling-edge detection
        n.sync1 = pins_i;
        n.sync2 = s.sync1;
        if (smp) begin
            n.sampled = s.sync2;
            n.fell = ttc_pins_s'(s.sampled & ~s.sync2);
        end

        // Timers 0 and 1
        m0 = s.timer_mode_register.tmr0;
        m1 = s.timer_mode_register.tmr1;
        md0 = {m0.mode_select_high, m0.mode_select_low};
        md1 = {m1.mode_select_high, m1.mode_select_low};
        t0m3 = (md0 == 2'd3);
        en0 = s.ctl.timer0_run_bit
              & (~m0.gate_enable | s.sync2.gate_pin_zero);
        inc0 = upd & en0
               & (m0.function_select ? s.fell.count_input_zero : 1'b1);
        en1 = (t0m3 | s.ctl.timer1_run_bit)
              & (~m1.gate_enable | s.sync2.gate_pin_one);
        inc1 = upd & en1 & (md1 != 2'd3)
               & (m1.function_select ? s.fell.count_input_one : 1'b1);
        set0 = 1'b0;
        set1 = 1'b0;
        r0 = tstep(md0, s.timer0_count_high_byte, s.timer0_count_low_byte);
        r1 = tstep(md1, s.timer1_count_high_byte, s.timer1_count_low_byte);
        if (t0m3) begin
            if (inc0) begin
                {set0, n.timer0_count_low_byte} =
                    {1'b0, s.timer0_count_low_byte} + 9'h001;
            end
            if (upd && s.ctl.timer1_run_bit) begin
                {set1, n.timer0_count_high_byte} =
                    {1'b0, s.timer0_count_high_byte} + 9'h001;
            end
        end else if (inc0) begin
            n.timer0_count_high_byte = r0.hi;
            n.timer0_count_low_byte = r0.lo;
            set0 = r0.ovf;
        end
        if (inc1) begin
            n.timer1_count_high_byte = r1.hi;
            n.timer1_count_low_byte = r1.lo;
        end
        n.t1_pulse = inc1 & r1.ovf;
        if (!t0m3) begin
            set1 = inc1 & r1.ovf;
        end

        // Timer 2
        c2 = s.timer2_control_register;
        baud = c2.receive_clock_select | c2.transmit_clock_select;
        updown = ~baud & ~c2.capture_reload_select & s.down_count_enable;
        inc2 = upd & c2.timer2_run_bit
               & (c2.timer2_function_select ? s.fell.count_input_two
                                            : 1'b1);
        ex2 = upd & c2.external_trigger_enable & s.fell.timer2_trigger_pin;
        cnt2 = {s.timer2_count_high_byte, s.timer2_count_low_byte};
        cap2 = {s.capture_high_byte, s.capture_low_byte};
        nt2 = cnt2;
        ncap = cap2;
        set_tf2 = 1'b0;
        set_external_trigger_flag = 1'b0;
        tog_external_trigger_flag = 1'b0;
        n.t2_pulse = 1'b0;
        if (baud) begin
            if (inc2) begin
                n.t2_pulse = &cnt2;
                nt2 = (&cnt2) ? cap2 : cnt2 + 16'h0001;
            end
            set_external_trigger_flag = ex2;
        end else if (c2.capture_reload_select) begin
            if (inc2) begin
                nt2 = cnt2 + 16'h0001;
                set_tf2 = &cnt2;
            end
            if (ex2) begin
                ncap = cnt2;
                set_external_trigger_flag = 1'b1;
            end
        end else if (!s.down_count_enable) begin
            if (ex2) begin
                nt2 = cap2;
                set_external_trigger_flag = 1'b1;
            end else if (inc2) begin
                nt2 = (&cnt2) ? cap2 : cnt2 + 16'h0001;
                set_tf2 = &cnt2;
            end
        end else if (inc2) begin
            if (s.sampled.timer2_trigger_pin) begin
                nt2 = (&cnt2) ? cap2 : cnt2 + 16'h0001;
                set_tf2 = &cnt2;
                tog_external_trigger_flag = &cnt2;
            end else begin
                nt2 = (cnt2 == cap2) ? 16'hffff
                                     : cnt2 - 16'h0001;
                set_tf2 = (cnt2 == cap2);
                tog_external_trigger_flag = (cnt2 == cap2);
            end
        end
        n.timer2_count_high_byte = nt2[15:8];
        n.timer2_count_low_byte = nt2[7:0];
        n.capture_high_byte = ncap[15:8];
        n.capture_low_byte = ncap[7:0];

        // Software writes to data registers take precedence over counting
        if (wsel(`TTC_A_MODE)) begin
            n.timer_mode_register = ttc_mode_s'(sfr_wdata_i);
        end
        if (wsel(`TTC_A_C0L)) begin
            n.timer0_count_low_byte = sfr_wdata_i;
        end
        if (wsel(`TTC_A_C0H)) begin
            n.timer0_count_high_byte = sfr_wdata_i;
        end
        if (wsel(`TTC_A_C1L)) begin
            n.timer1_count_low_byte = sfr_wdata_i;
        end
        if (wsel(`TTC_A_C1H)) begin
            n.timer1_count_high_byte = sfr_wdata_i;
        end
        if (wsel(`TTC_A_T2M)) begin
            n.down_count_enable = sfr_wdata_i[`TTC_DOWN_COUNT_ENABLE_BIT];
        end
        if (wsel(`TTC_A_CAPL)) begin
            n.capture_low_byte = sfr_wdata_i;
        end
        if (wsel(`TTC_A_CAPH)) begin
            n.capture_high_byte = sfr_wdata_i;
        end
        if (wsel(`TTC_A_C2L)) begin
            n.timer2_count_low_byte = sfr_wdata_i;
        end
        if (wsel(`TTC_A_C2H)) begin
            n.timer2_count_high_byte = sfr_wdata_i;
        end

        // Flags: hardware set beats a clear in the same cycle
        ctl_w = wsel(`TTC_A_CTL)
                ? ttc_ctl_s'(sfr_wdata_i[`TTC_CTL_LSB +: 4]) : s.ctl;
        n.ctl = ctl_w;
        n.ctl.timer0_overflow_flag = (ctl_w.timer0_overflow_flag
                                      & ~tmr0_vector_ack_i) | set0;
        n.ctl.timer1_overflow_flag = (ctl_w.timer1_overflow_flag
                                      & ~tmr1_vector_ack_i) | set1;
        t2c_w = wsel(`TTC_A_T2C) ? ttc_t2c_s'(sfr_wdata_i) : c2;
        n.timer2_control_register = t2c_w;
        n.timer2_control_register.timer2_overflow_flag =
            t2c_w.timer2_overflow_flag | set_tf2;
        n.timer2_control_register.external_trigger_flag =
            (t2c_w.external_trigger_flag ^ tog_external_trigger_flag) | set_external_trigger_flag;
        n.irq2 = n.timer2_control_register.timer2_overflow_flag
                 | (n.timer2_control_register.external_trigger_flag
                    & ~updown);

        // Registered read data
        if (sfr_rd_i) begin
            case (sfr_addr_i)
                `TTC_A_CTL: n.rdata = {s.ctl, 4'h0};
                `TTC_A_MODE: n.rdata = s.timer_mode_register;
                `TTC_A_C0L: n.rdata = s.timer0_count_low_byte;
                `TTC_A_C0H: n.rdata = s.timer0_count_high_byte;
                `TTC_A_C1L: n.rdata = s.timer1_count_low_byte;
                `TTC_A_C1H: n.rdata = s.timer1_count_high_byte;
                `TTC_A_T2C: n.rdata = c2;
                `TTC_A_T2M: n.rdata = {7'h00, s.down_count_enable};
                `TTC_A_CAPL: n.rdata = s.capture_low_byte;
                `TTC_A_CAPH: n.rdata = s.capture_high_byte;
                `TTC_A_C2L: n.rdata = s.timer2_count_low_byte;
                `TTC_A_C2H: n.rdata = s.timer2_count_high_byte;
                default: n.rdata = `TTC_RST_BYTE;
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= `TTC_RST_STATE;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state register
    assign sfr_rdata_o = s.rdata;
    assign timer0_overflow_flag_o = s.ctl.timer0_overflow_flag;
    assign timer1_overflow_flag_o = s.ctl.timer1_overflow_flag;
    assign timer2_irq_o = s.irq2;
    assign timer1_overflow_pulse_o = s.t1_pulse;
    assign timer2_reload_pulse_o = s.t2_pulse;

    // Checks on the counting behaviour
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_mach_cycle_len: assert property (
        (upd && !six_clk_mode_i && !$changed(six_clk_mode_i))
        |-> ##12 upd)
        else $error("update tick not 12 clocks apart");

    a_edge_sample: assert property (
        (smp && s.sampled.count_input_zero && !s.sync2.count_input_zero)
        |=> s.fell.count_input_zero)
        else $error("falling edge on count pin missed");

    a_count_late: assert property (
        (inc0 && m0.function_select) |-> upd && $past(s.fell.count_input_zero))
        else $error("counter stepped without a sampled edge");

    a_gate_stop: assert property (
        (!s.ctl.timer0_run_bit
         || (m0.gate_enable && !s.sync2.gate_pin_zero)) |-> !inc0)
        else $error("timer 0 counted while stopped");

    a_mode0_wrap: assert property (
        (inc0 && md0 == 2'd0 && s.timer0_count_high_byte == 8'hff
         && s.timer0_count_low_byte[4:0] == 5'h1f && !sfr_wr_i)
        |=> s.ctl.timer0_overflow_flag && s.timer0_count_high_byte == 8'h00
            && s.timer0_count_low_byte[4:0] == 5'h00)
        else $error("13-bit wrap wrong");

    a_mode1_wrap: assert property (
        (inc0 && md0 == 2'd1 && !sfr_wr_i
         && {s.timer0_count_high_byte, s.timer0_count_low_byte} == 16'hffff)
        |=> s.ctl.timer0_overflow_flag
            && {s.timer0_count_high_byte, s.timer0_count_low_byte} == 16'h0)
        else $error("16-bit wrap wrong");

    a_mode2_reload: assert property (
        (inc0 && md0 == 2'd2 && s.timer0_count_low_byte == 8'hff && !sfr_wr_i)
        |=> s.timer0_count_low_byte == $past(s.timer0_count_high_byte)
            && $stable(s.timer0_count_high_byte))
        else $error("8-bit reload wrong");

    a_t1_frozen: assert property (
        (md1 == 2'd3 && !sfr_wr_i)
        |=> $stable({s.timer1_count_high_byte, s.timer1_count_low_byte}))
        else $error("timer 1 moved in mode 3");

    a_t2_capture: assert property (
        (ex2 && !baud && c2.capture_reload_select && !sfr_wr_i)
        |=> {s.capture_high_byte, s.capture_low_byte} == $past(cnt2)
            && s.timer2_control_register.external_trigger_flag)
        else $error("timer 2 capture wrong");

    a_t2_no_hw_clr: assert property (
        (s.timer2_control_register.timer2_overflow_flag && !sfr_wr_i)
        |=> s.timer2_control_register.timer2_overflow_flag)
        else $error("timer 2 flag cleared by hardware");

endmodule // ttc_top

`default_nettype wire

// ### rtl/ttc_defs.svh
/*
 * Constants of the triple timer/counter unit: register indices, field
 * positions, reset values and machine-cycle timing.
 * Assumes it is included by bare name from the rtl/ folder.
 */
`ifndef TTC_DEFS_SVH
`define TTC_DEFS_SVH

// Register indices on the special function register port
`define TTC_A_CTL 4'h0
`define TTC_A_MODE 4'h1
`define TTC_A_C0L 4'h2
`define TTC_A_C0H 4'h3
`define TTC_A_C1L 4'h4
`define TTC_A_C1H 4'h5
`define TTC_A_T2C 4'h6
`define TTC_A_T2M 4'h7
`define TTC_A_CAPL 4'h8
`define TTC_A_CAPH 4'h9
`define TTC_A_C2L 4'ha
`define TTC_A_C2H 4'hb

// Field positions
`define TTC_CTL_LSB 4
`define TTC_DOWN_COUNT_ENABLE_BIT 0

// Reset values
`define TTC_RST_STATE '0
`define TTC_RST_BYTE 8'h00

// Machine cycle timing, in clocks
`define TTC_MC_CLKS_12 12
`define TTC_MC_CLKS_6 6
`define TTC_MC12_LAST 4'(`TTC_MC_CLKS_12 - 1)
`define TTC_MC6_LAST 4'(`TTC_MC_CLKS_6 - 1)
`define TTC_UPD_PH 4'h2
`define TTC_SMP_PH 4'h3

`endif

// ### rtl/ttc_pkg.sv
/*
 * Types of the triple timer/counter unit.
 * Assumes ttc_defs.svh supplies the numeric constants.
 */
package ttc_pkg;

    // External pins, one bit each
    typedef struct packed {
        logic gate_pin_one;
        logic gate_pin_zero;
        logic timer2_trigger_pin;
        logic count_input_two;
        logic count_input_one;
        logic count_input_zero;
    } ttc_pins_s;

    // Per-timer nibble of the mode register
    typedef struct packed {
        logic gate_enable;
        logic function_select;
        logic mode_select_high;
        logic mode_select_low;
    } ttc_tmode_s;

    typedef struct packed {
        ttc_tmode_s tmr1;
        ttc_tmode_s tmr0;
    } ttc_mode_s;

    typedef struct packed {
        logic timer1_overflow_flag;
        logic timer1_run_bit;
        logic timer0_overflow_flag;
        logic timer0_run_bit;
    } ttc_ctl_s;

    typedef struct packed {
        logic timer2_overflow_flag;
        logic external_trigger_flag;
        logic receive_clock_select;
        logic transmit_clock_select;
        logic external_trigger_enable;
        logic timer2_run_bit;
        logic timer2_function_select;
        logic capture_reload_select;
    } ttc_t2c_s;

    // Result of one count step of timer 0 or 1
    typedef struct packed {
        logic ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } ttc_step_s;

    // Whole state of the unit
    typedef struct packed {
        logic [3:0] phase;
        ttc_pins_s sync1;
        ttc_pins_s sync2;
        ttc_pins_s sampled;
        ttc_pins_s fell;
        ttc_mode_s timer_mode_register;
        ttc_ctl_s ctl;
        logic [7:0] timer0_count_high_byte;
        logic [7:0] timer0_count_low_byte;
        logic [7:0] timer1_count_high_byte;
        logic [7:0] timer1_count_low_byte;
        ttc_t2c_s timer2_control_register;
        logic down_count_enable;
        logic [7:0] capture_high_byte;
        logic [7:0] capture_low_byte;
        logic [7:0] timer2_count_high_byte;
        logic [7:0] timer2_count_low_byte;
        logic [7:0] rdata;
        logic t1_pulse;
        logic t2_pulse;
        logic irq2;
    } ttc_state_s;

endpackage

// ### testbench/ttc_pin_model.sv
/*
 * Model of the external pins: count inputs, gate pins and trigger pin.
 * Assumes the bench calls its tasks at falling clock edges.
 */
`timescale 1ns/10ps
`default_nettype none

module ttc_pin_model
    import ttc_pkg::*;
(
    input wire logic sys_clk_i,
    output var ttc_pins_s pins_o
);
    // All lines idle high until told otherwise
    initial begin
        pins_o = '1;
    end

    // Static levels for gates, trigger and idle count inputs
    task automatic set_levels(input logic [5:0] p);
        pins_o = p;
    endtask

    // Low pulses of 24 clocks, one every 48 clocks, on masked lines, below clock/24
    task automatic burst(input logic [5:0] m, input int n);
        repeat (n) begin
            @(negedge sys_clk_i);
            pins_o = pins_o & ~m;
            repeat (24) @(negedge sys_clk_i);
            pins_o = pins_o | m;
            repeat (23) @(negedge sys_clk_i);
        end
    endtask
endmodule // ttc_pin_model

`default_nettype wire

// ### testbench/tb_triple_timer_counter_unit.sv
/*
 * Self-checking bench of the triple timer/counter unit.
 * Assumes ttc_pkg, ttc_defs.svh and the pin model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ttc_defs.svh"

module tb_triple_timer_counter_unit
    import ttc_pkg::*;
;
    typedef struct packed {
        int t;
        logic [7:0] md;
        logic [7:0] run;
        logic [15:0] st;
        logic [15:0] cap;
        logic [5:0] pn;
        int n;
        logic [15:0] ex;
        int fl;
    } ttc_row_s;
    // Timer, mode, run, start, capture, pins, cycles, count, flag
    localparam ttc_row_s rows [17] = '{
        '{0, 8'h01, 8'h10, 16'hfffe, '0, 6'h3f, 3, 16'h0001, 1},
        '{0, 8'h00, 8'h10, 16'hff1e, '0, 6'h3f, 3, 16'h0001, 1},
        '{0, 8'h00, 8'h10, 16'h121f, '0, 6'h3f, 1, 16'h1300, 0},
        '{0, 8'h02, 8'h10, 16'h80fe, '0, 6'h3f, 3, 16'h8081, 1},
        '{0, 8'h09, 8'h10, 16'h0010, '0, 6'h2f, 3, 16'h0010, 0},
        '{0, 8'h09, 8'h10, 16'h0010, '0, 6'h3f, 3, 16'h0013, 0},
        '{0, 8'h01, 8'h00, 16'h0010, '0, 6'h3f, 3, 16'h0010, 0},
        '{0, 8'h03, 8'h50, 16'h10fe, '0, 6'h3f, 3, 16'h1301, 1},
        '{1, 8'h10, 8'h40, 16'hffff, '0, 6'h3f, 2, 16'h0001, 1},
        '{1, 8'h30, 8'h40, 16'h5a5a, '0, 6'h3f, 3, 16'h5a5a, 0},
        '{1, 8'h90, 8'h40, 16'h0010, '0, 6'h1f, 3, 16'h0010, 0},
        '{2, 8'h00, 8'h05, 16'hfffe, '0, 6'h3f, 3, 16'h0001, 1},
        '{2, 8'h00, 8'h04, 16'hfffe, 16'h1234, 6'h3f, 3, 16'h1235, 1},
        '{2, 8'h01, 8'h04, 16'hffff, 16'h4000, 6'h3f, 2, 16'h4001, 1},
        '{2, 8'h01, 8'h04, 16'h0101, 16'h0100, 6'h37, 3, 16'hfffe, 1},
        '{2, 8'h00, 8'h14, 16'hfffe, 16'h0500, 6'h3f, 3, 16'h0501, 0},
        '{2, 8'h00, 8'h06, 16'h0010, '0, 6'h3f, 3, 16'h0010, 0}};
    // Trigger pin cases: capture, reload, baud
    localparam ttc_row_s trig [3] = '{
        '{2, 8'h00, 8'h09, 16'h1234, '0, 6'h3f, 0, 16'h1234, 1},
        '{2, 8'h00, 8'h08, 16'h0005, 16'h2222, 6'h3f, 0, 16'h2222, 1},
        '{2, 8'h00, 8'h18, 16'h0005, 16'h2222, 6'h3f, 0, 16'h0005, 1}};
    logic sys_clk;
    logic rst_b;
    logic six_clk;
    logic ack0;
    logic ack1;
    logic sfr_wr;
    logic sfr_rd;
    logic [3:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic [7:0] v;
    logic [7:0] w;
    logic tf0;
    logic tf1;
    logic irq;
    ttc_pins_s pins;
    logic p1;
    logic p2;
    int n1 = 0;
    int n2 = 0;
    int num_errors = 0;
    int checks_done = 0;

    ttc_top dut_u (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
        .six_clk_mode_i(six_clk), .pins_i(pins),
        .tmr0_vector_ack_i(ack0), .tmr1_vector_ack_i(ack1),
        .sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd),
        .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata),
        .timer0_overflow_flag_o(tf0), .timer1_overflow_flag_o(tf1),
        .timer2_irq_o(irq), .timer1_overflow_pulse_o(p1),
        .timer2_reload_pulse_o(p2));
    ttc_pin_model pin_u (.sys_clk_i(sys_clk), .pins_o(pins));

    // Clock of 100 ns period
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Count one-cycle pulses at the falling edge, where they are settled
    always @(negedge sys_clk) begin
        n1 <= n1 + int'(p1);
        n2 <= n2 + int'(p2);
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge sys_clk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask

    task automatic do_reset();
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
    endtask

    // Load, run for n machine cycles exactly, stop, read back
    task automatic run_row(input ttc_row_s r, input int cpm);
        logic [3:0] base;
        logic [3:0] ctl;
        logic [7:0] lo;
        logic [7:0] hi;
        logic f;
        base = (r.t == 2'd2) ? `TTC_A_C2L :
            (r.t == 2'd1) ? `TTC_A_C1L : `TTC_A_C0L;
        ctl = (r.t == 2'd2) ? `TTC_A_T2C : `TTC_A_CTL;
        pin_u.set_levels(r.pn);
        repeat (16) @(negedge sys_clk);
        wr((r.t == 2'd2) ? `TTC_A_T2M : `TTC_A_MODE, r.md);
        wr(`TTC_A_CAPL, r.cap[7:0]);
        wr(`TTC_A_CAPH, r.cap[15:8]);
        wr(base, r.st[7:0]);
        wr(base + 4'h1, r.st[15:8]);
        wr(ctl, r.run);
        repeat (cpm * int'(r.n) - 2) @(negedge sys_clk);
        f = (r.t == 2'd0) ? tf0 : (r.t == 2'd1) ? tf1 : irq;
        chk(16'(f), 16'(r.fl));
        wr(ctl, 8'h00);
        rd(base, lo);
        rd(base + 4'h1, hi);
        chk({hi, lo}, r.ex);
    endtask

    // Hang guard, far beyond the expected run length
    initial begin
        #3_000_000;
        num_errors++;
        results();
    end

    // Main sequence
    initial begin
        {rst_b, six_clk, ack0, ack1, sfr_wr, sfr_rd} = '0;
        sfr_addr = 4'h0;
        sfr_wdata = 8'h00;
        do_reset();
        wr(4'hc, 8'hff);
        for (int a = 0; a < 13; a++) begin
            rd(4'(a), v);
            chk(16'(v), 16'h0000);
        end
        foreach (rows[i]) run_row(rows[i], 12);
        // One timer 1 overflow and one baud reload happen in the rows
        chk({n1[7:0], n2[7:0]}, 16'h0101);
        // Counter function on both count inputs, five edges each
        wr(`TTC_A_MODE, 8'h55);
        for (int a = 2; a < 6; a++) wr(4'(a), 8'h00);
        wr(`TTC_A_CTL, 8'h50);
        pin_u.burst(6'h03, 5);
        repeat (40) @(negedge sys_clk);
        wr(`TTC_A_CTL, 8'h00);
        rd(`TTC_A_C0L, v);
        rd(`TTC_A_C1L, w);
        chk({v, w}, 16'h0505);
        // Split timer 0: both bytes wrap; acks clear timer 0/1 flags only
        wr(`TTC_A_MODE, 8'h03);
        wr(`TTC_A_C0H, 8'hff);
        wr(`TTC_A_C0L, 8'hff);
        wr(`TTC_A_CTL, 8'h50);
        repeat (30) @(negedge sys_clk);
        wr(`TTC_A_T2C, 8'h80);
        chk(16'({tf1, tf0, irq}), 16'h0007);
        {ack0, ack1} = 2'b11;
        @(negedge sys_clk);
        {ack0, ack1} = 2'b00;
        chk(16'({tf1, tf0, irq}), 16'h0001);
        wr(`TTC_A_CTL, 8'h00);
        // Trigger pin falling edge: capture, reload, baud flag
        foreach (trig[i]) begin
            wr(`TTC_A_T2C, 8'h00);
            wr(`TTC_A_CAPL, trig[i].cap[7:0]);
            wr(`TTC_A_CAPH, trig[i].cap[15:8]);
            wr(`TTC_A_C2L, trig[i].st[7:0]);
            wr(`TTC_A_C2H, trig[i].st[15:8]);
            wr(`TTC_A_T2C, trig[i].run);
            pin_u.burst(6'h08, 1);
            repeat (30) @(negedge sys_clk);
            chk(16'(irq), 16'(trig[i].fl));
            rd(`TTC_A_C2L, v);
            rd(`TTC_A_C2H, w);
            chk({w, v}, trig[i].ex);
            rd(`TTC_A_CAPL, v);
            rd(`TTC_A_CAPH, w);
            chk({w, v}, trig[i].run[0] ? trig[i].st : trig[i].cap);
        end
        // Second reset into six clocks per machine cycle
        six_clk = 1'b1;
        do_reset();
        rd(`TTC_A_T2C, v);
        chk(16'(v), 16'h0000);
        run_row(rows[0], 6);
        results();
    end
endmodule // tb_triple_timer_counter_unit

`default_nettype wire
